/* logic/spc_pkg.sv */
`default_nettype none
package spc_pkg;
	// register byte offsets
	localparam logic [7:0] OFS_FREE    = 8'h00;
	localparam logic [7:0] OFS_COMMIT  = 8'h04;
	localparam logic [7:0] OFS_ENABLE  = 8'h08;
	localparam logic [7:0] OFS_STG_ID  = 8'h0C;
	localparam logic [7:0] OFS_RUN_ID  = 8'h10;
	localparam logic [7:0] OFS_CAP     = 8'h14;
	localparam logic [7:0] OFS_MODE    = 8'h18;
	localparam logic [7:0] OFS_READY   = 8'h1C;
	localparam logic [7:0] OFS_REP_LFT = 8'h20;
	localparam logic [7:0] OFS_REP_SET = 8'h24;
	localparam logic [7:0] OFS_CLEAR   = 8'h28;
	localparam logic [7:0] OFS_STATUS  = 8'h2C;
	localparam logic [7:0] OFS_TIMEOUT = 8'h30;
	localparam logic [7:0] OFS_STG_DAT = 8'h34;
	// mode encodings
	localparam logic [1:0] MODE_OFF   = 2'h0;
	localparam logic [1:0] MODE_BATCH = 2'h1;
	localparam logic [1:0] MODE_QUEUE = 2'h2;
	localparam logic [1:0] MODE_BAD   = 2'h3;
	// status encodings
	localparam logic [1:0] STAT_IDLE = 2'h0;
	localparam logic [1:0] STAT_EXEC = 2'h1;
	localparam logic [1:0] STAT_WAIT = 2'h2;
	localparam logic [1:0] STAT_DONE = 2'h3;
	// repetition limits
	localparam logic [31:0] REP_MIN = 32'h0000_0001;
	localparam logic [31:0] REP_MAX = 32'h003D_0900;
	// millisecond tick from the system clock
	localparam int MS_NS     = 1000000;
	localparam int CLK_NS    = 100;
	localparam int MS_CYCLES = (MS_NS + CLK_NS - 1) / CLK_NS;
	// ahb transfer type bit that marks an active transfer
	localparam int HTRANS_ACT = 1;
	typedef enum logic [3:0] {
		S_IDLE = 4'b0001,
		S_EXEC = 4'b0010,
		S_WAIT = 4'b0100,
		S_DONE = 4'b1000
	} spc_state_t;
endpackage
`default_nettype wire

/* logic/spc_slot_queue.sv */
`default_nettype none
// circular slot store; DEPTH must be a power of two so pointers wrap
module spc_slot_queue #(
	parameter int DEPTH = 8,
	parameter int QW    = 64,
	parameter int CW    = $clog2(DEPTH + 1)
) (
	input  wire logic          sys_clk_i,
	input  wire logic          srst_i,
	input  wire logic          flush_i,
	input  wire logic          push_i,
	input  wire logic [QW-1:0] push_data_i,
	input  wire logic          pop_i,
	input  wire logic [CW-1:0] rd_ofs_i,
	output logic      [QW-1:0] rd_data_o,
	output logic      [CW-1:0] count_o,
	output logic      [CW-1:0] free_o
);
	localparam int AW = $clog2(DEPTH);
	localparam logic [CW-1:0] CAP = CW'(DEPTH);

	logic [QW-1:0] mem_r [DEPTH];
	logic [AW-1:0] head_r;
	logic [AW-1:0] tail_r;
	logic [CW-1:0] cnt_r;

	// full and empty guards keep a stray push or pop harmless
	wire do_push = push_i & (cnt_r != CAP);
	wire do_pop  = pop_i & (cnt_r != '0);

	// slots fill at the tail and drain from the head, fifo order
	always_ff @(posedge sys_clk_i) begin
		if (srst_i || flush_i) begin
			head_r <= '0;
			tail_r <= '0;
			cnt_r  <= '0;
		end else begin
			if (do_push) tail_r <= tail_r + 1'b1;
			if (do_pop) head_r <= head_r + 1'b1;
			cnt_r <= cnt_r + CW'(do_push) - CW'(do_pop);
		end
	end

	// storage itself needs no reset
	always_ff @(posedge sys_clk_i) begin
		if (do_push) mem_r[tail_r] <= push_data_i;
	end

	assign rd_data_o = mem_r[head_r + rd_ofs_i[AW-1:0]];
	assign count_o   = cnt_r;
	assign free_o    = CAP - cnt_r;
endmodule
`default_nettype wire

/* logic/spc_exec_timer.sv */
`default_nettype none
// millisecond watchdog for one sequence run
module spc_exec_timer #(
	parameter int MS_CYCLES = spc_pkg::MS_CYCLES
) (
	input  wire logic        sys_clk_i,
	input  wire logic        srst_i,
	input  wire logic        clear_i,
	input  wire logic        run_i,
	input  wire logic [31:0] limit_i,
	output logic             expire_o
);
	localparam int DW = (MS_CYCLES > 1) ? $clog2(MS_CYCLES) : 1;
	localparam logic [DW-1:0] DIV_TOP = DW'(MS_CYCLES - 1);

	logic [DW-1:0] div_r;
	logic [31:0]   ms_r;
	logic          exp_r;

	wire tick   = run_i & (div_r == DIV_TOP);
	wire [31:0] ms_inc = ms_r + 32'h0000_0001;
	// a zero limit never matches since the limit_i check masks hit; zero turns the watchdog off
	wire hit = tick & (limit_i != 32'h0000_0000) & (ms_inc == limit_i);

	// divider gives a one-cycle ms enable while a sequence runs
	always_ff @(posedge sys_clk_i) begin
		if (srst_i || clear_i) begin
			div_r <= '0;
			ms_r  <= '0;
			exp_r <= 1'b0;
		end else begin
			if (run_i) div_r <= tick ? '0 : div_r + 1'b1;
			if (tick) ms_r <= ms_inc;
			exp_r <= hit;
		end
	end

	assign expire_o = exp_r;
endmodule
`default_nettype wire

/* logic/spc_pipeliner.sv */
`default_nettype none
// sequence pipeliner control with an ahb-lite register slave
module spc_pipeliner #(
	parameter int DEPTH     = 8,
	parameter int DW        = 32,
	parameter int MS_CYCLES = spc_pkg::MS_CYCLES
) (
	input  wire logic          sys_clk_i,
	input  wire logic          srst_i,
	input  wire logic          hsel_i,
	input  wire logic [31:0]   haddr_i,
	input  wire logic [1:0]    htrans_i,
	input  wire logic          hwrite_i,
	input  wire logic [2:0]    hsize_i,
	input  wire logic [31:0]   hwdata_i,
	input  wire logic          hready_i,
	output logic      [31:0]   hrdata_o,
	output logic               hreadyout_o,
	output logic               hresp_o,
	output logic               seq_start_o,
	output logic      [DW-1:0] seq_id_o,
	output logic      [DW-1:0] seq_data_o,
	output logic               seq_abort_o,
	input  wire logic          seq_done_i,
	output logic               wavegen_reset_o
);
	localparam int CW = $clog2(DEPTH + 1);
	localparam int QW = 2 * DW;

	// widen a slot count to a bus word
	function automatic logic [31:0] to_word(input logic [CW-1:0] v);
		to_word = 32'(v);
	endfunction

	// keep the repetition setting inside its legal span
	function automatic logic [31:0] clamp_rep(input logic [31:0] v);
		if (v < spc_pkg::REP_MIN) clamp_rep = spc_pkg::REP_MIN;
		else if (v > spc_pkg::REP_MAX) clamp_rep = spc_pkg::REP_MAX;
		else clamp_rep = v;
	endfunction

	// one-hot state to the status code software reads
	function automatic logic [1:0] stat_code(input spc_pkg::spc_state_t s);
		case (s)
			spc_pkg::S_EXEC: stat_code = spc_pkg::STAT_EXEC;
			spc_pkg::S_WAIT: stat_code = spc_pkg::STAT_WAIT;
			spc_pkg::S_DONE: stat_code = spc_pkg::STAT_DONE;
			default:         stat_code = spc_pkg::STAT_IDLE;
		endcase
	endfunction

	// bus side state
	logic       pend_r;
	logic       wr_r;
	logic [7:0] adr_r;
	logic [31:0] hrdata_r;

	// control registers
	logic [1:0]  mode_r;
	logic        enable_r;
	logic [31:0] rep_set_r;
	logic [31:0] reps_left_r;
	logic [31:0] reps_nxt;
	logic [31:0] limit_r;
	logic [DW-1:0] stg_data_r;
	logic [DW-1:0] stg_id_r;
	logic [DW-1:0] run_id_r;
	logic [DW-1:0] seq_data_r;
	logic [CW-1:0] ofs_r;
	logic [CW-1:0] ofs_nxt;
	logic        launch;
	logic        launch_r;
	logic        start_r;
	logic        pop;
	logic        wgr_r;
	logic        abort_r;
	spc_pkg::spc_state_t state_r;
	spc_pkg::spc_state_t st_nxt;

	logic [QW-1:0] q_rd;
	logic [CW-1:0] q_count;
	logic [CW-1:0] q_free;
	logic          tmo;

	// address phase is taken only when the bus is ready
	wire addr_ok = hsel_i & htrans_i[spc_pkg::HTRANS_ACT] & hready_i;
	wire do_wr   = pend_r & wr_r;
	wire do_rd   = pend_r & ~wr_r;

	// write strobes, one per writable register
	wire wr_commit = do_wr && (adr_r == spc_pkg::OFS_COMMIT);
	wire wr_enable = do_wr && (adr_r == spc_pkg::OFS_ENABLE);
	wire wr_mode   = do_wr && (adr_r == spc_pkg::OFS_MODE);
	wire wr_repset = do_wr && (adr_r == spc_pkg::OFS_REP_SET);
	wire wr_clear  = do_wr && (adr_r == spc_pkg::OFS_CLEAR);
	wire wr_tmo    = do_wr && (adr_r == spc_pkg::OFS_TIMEOUT);
	wire wr_stg    = do_wr && (adr_r == spc_pkg::OFS_STG_DAT);

	// unknown mode codes are dropped so the field stays decodable
	wire mode_ok  = (hwdata_i[31:2] == 30'h0000_0000) && (hwdata_i[1:0] != spc_pkg::MODE_BAD);
	wire mode_chg = wr_mode && mode_ok && (hwdata_i[1:0] != mode_r);
	wire flush    = mode_chg | wr_clear;

	wire is_batch = (mode_r == spc_pkg::MODE_BATCH);
	wire is_queue = (mode_r == spc_pkg::MODE_QUEUE);
	wire run_ok   = enable_r && (mode_r != spc_pkg::MODE_OFF);
	wire finish   = seq_done_i | tmo;

	// batch commits only while parked; queue commits any time
	wire ready = (mode_r != spc_pkg::MODE_OFF) && (q_free != '0) && !flush
		&& (is_queue || (!enable_r && state_r == spc_pkg::S_IDLE));
	wire push  = wr_commit & ready;

	// derived read values
	wire [31:0] rep_rd  = is_batch ? rep_set_r : spc_pkg::REP_MIN;
	wire [31:0] left_rd = is_batch ? reps_left_r : spc_pkg::REP_MIN;

	// register read decode; unmapped offsets read zero
	wire [31:0] rd_mux =
		(adr_r == spc_pkg::OFS_FREE)    ? to_word(q_free) :
		(adr_r == spc_pkg::OFS_ENABLE)  ? {31'h0000_0000, enable_r} :
		(adr_r == spc_pkg::OFS_STG_ID)  ? 32'(stg_id_r) :
		(adr_r == spc_pkg::OFS_RUN_ID)  ? 32'(run_id_r) :
		(adr_r == spc_pkg::OFS_CAP)     ? 32'(DEPTH) :
		(adr_r == spc_pkg::OFS_MODE)    ? {30'h0000_0000, mode_r} :
		(adr_r == spc_pkg::OFS_READY)   ? {31'h0000_0000, ready} :
		(adr_r == spc_pkg::OFS_REP_LFT) ? left_rd :
		(adr_r == spc_pkg::OFS_REP_SET) ? rep_rd :
		(adr_r == spc_pkg::OFS_STATUS)  ? {30'h0000_0000, stat_code(state_r)} :
		(adr_r == spc_pkg::OFS_TIMEOUT) ? limit_r :
		(adr_r == spc_pkg::OFS_STG_DAT) ? 32'(stg_data_r) :
		32'h0000_0000;

	// one wait state: writes land and read data is caught before hready rises
	always_ff @(posedge sys_clk_i) begin
		if (srst_i) begin
			pend_r   <= 1'b0;
			wr_r     <= 1'b0;
			adr_r    <= 8'h00;
			hrdata_r <= 32'h0000_0000;
		end else begin
			pend_r <= addr_ok;
			if (addr_ok) begin
				wr_r  <= hwrite_i;
				adr_r <= haddr_i[7:0];
			end
			if (do_rd) hrdata_r <= rd_mux;
		end
	end

	assign hreadyout_o = ~pend_r;
	assign hrdata_o    = hrdata_r;
	assign hresp_o     = 1'b0;

	// software settings
	always_ff @(posedge sys_clk_i) begin
		if (srst_i) begin
			mode_r     <= spc_pkg::MODE_OFF;
			enable_r   <= 1'b0;
			rep_set_r  <= spc_pkg::REP_MIN;
			limit_r    <= 32'h0000_0000;
			stg_data_r <= '0;
			wgr_r      <= 1'b0;
		end else begin
			if (mode_chg) mode_r <= hwdata_i[1:0];
			if (flush) enable_r <= 1'b0;
			else if (wr_enable) enable_r <= hwdata_i[0];
			if (mode_chg) rep_set_r <= spc_pkg::REP_MIN;
			else if (wr_repset && is_batch) rep_set_r <= clamp_rep(hwdata_i);
			if (wr_tmo) limit_r <= hwdata_i;
			if (wr_stg) stg_data_r <= DW'(hwdata_i);
			wgr_r <= mode_chg;
		end
	end

	// staging id advances once per accepted commit
	always_ff @(posedge sys_clk_i) begin
		if (srst_i) stg_id_r <= '0;
		else if (push) stg_id_r <= stg_id_r + 1'b1;
	end

	// execution sequencing
	always_comb begin
		st_nxt   = state_r;
		ofs_nxt  = ofs_r;
		reps_nxt = reps_left_r;
		launch   = 1'b0;
		pop      = 1'b0;
		case (state_r)
			spc_pkg::S_IDLE: begin
				if (run_ok) begin
					reps_nxt = rep_set_r;
					ofs_nxt  = '0;
					if (q_count != '0) begin
						launch = 1'b1;
						st_nxt = spc_pkg::S_EXEC;
					end else if (is_queue) begin
						st_nxt = spc_pkg::S_WAIT;
					end else begin
						st_nxt = spc_pkg::S_DONE;
					end
				end
			end
			spc_pkg::S_EXEC: begin
				if (finish && is_queue) begin
					pop = 1'b1;
					if (!enable_r) st_nxt = spc_pkg::S_IDLE;
					else if (q_count > CW'(1)) launch = 1'b1;
					else st_nxt = spc_pkg::S_WAIT;
				end else if (finish && (ofs_r + 1'b1 < q_count)) begin
					ofs_nxt = ofs_r + 1'b1;
					if (enable_r) launch = 1'b1;
					else st_nxt = spc_pkg::S_IDLE;
				end else if (finish && enable_r && reps_left_r > spc_pkg::REP_MIN) begin
					reps_nxt = reps_left_r - spc_pkg::REP_MIN;
					ofs_nxt  = '0;
					launch   = 1'b1;
				end else if (finish) begin
					reps_nxt = 32'h0000_0000;
					st_nxt   = enable_r ? spc_pkg::S_DONE : spc_pkg::S_IDLE;
				end
			end
			spc_pkg::S_WAIT: begin
				if (!enable_r || !is_queue) begin
					st_nxt = spc_pkg::S_IDLE;
				end else if (q_count != '0) begin
					launch = 1'b1;
					st_nxt = spc_pkg::S_EXEC;
				end
			end
			spc_pkg::S_DONE: begin
				if (!enable_r || !is_batch) st_nxt = spc_pkg::S_IDLE;
			end
			default: st_nxt = spc_pkg::S_IDLE;
		endcase
	end

	// a flush wins over whatever the sequencer reports this cycle
	always_ff @(posedge sys_clk_i) begin
		if (srst_i) begin
			state_r     <= spc_pkg::S_IDLE;
			ofs_r       <= '0;
			reps_left_r <= spc_pkg::REP_MIN;
			launch_r    <= 1'b0;
		end else if (flush) begin
			state_r     <= spc_pkg::S_IDLE;
			ofs_r       <= '0;
			reps_left_r <= spc_pkg::REP_MIN;
			launch_r    <= 1'b0;
		end else begin
			state_r     <= st_nxt;
			ofs_r       <= ofs_nxt;
			reps_left_r <= reps_nxt;
			launch_r    <= launch;
		end
	end

	// slot data is read a cycle after launch, once the head (queue) or the offset (batch) has moved
	always_ff @(posedge sys_clk_i) begin
		if (srst_i) begin
			start_r    <= 1'b0;
			run_id_r   <= '0;
			seq_data_r <= '0;
			abort_r    <= 1'b0;
		end else begin
			start_r <= launch_r & ~flush;
			if (launch_r && !flush) begin
				run_id_r   <= q_rd[QW-1:DW];
				seq_data_r <= q_rd[DW-1:0];
			end
			abort_r <= tmo | (flush & (state_r == spc_pkg::S_EXEC));
		end
	end

	assign seq_start_o     = start_r;
	assign seq_id_o        = run_id_r;
	assign seq_data_o      = seq_data_r;
	assign seq_abort_o     = abort_r;
	assign wavegen_reset_o = wgr_r;

	spc_slot_queue #(
		.DEPTH (DEPTH),
		.QW    (QW),
		.CW    (CW)
	) u_queue (
		.sys_clk_i   (sys_clk_i),
		.srst_i      (srst_i),
		.flush_i     (flush),
		.push_i      (push),
		.push_data_i ({stg_id_r, stg_data_r}),
		.pop_i       (pop & ~flush),
		.rd_ofs_i    (is_batch ? ofs_r : CW'(0)),
		.rd_data_o   (q_rd),
		.count_o     (q_count),
		.free_o      (q_free)
	);

	spc_exec_timer #(
		.MS_CYCLES (MS_CYCLES)
	) u_timer (
		.sys_clk_i (sys_clk_i),
		.srst_i    (srst_i),
		.clear_i   (start_r | flush),
		.run_i     (state_r == spc_pkg::S_EXEC),
		.limit_i   (limit_r),
		.expire_o  (tmo)
	);

	// checks on the controller
	default clocking cb @(posedge sys_clk_i); endclocking
	default disable iff (srst_i);

	property p_no_room;
		(q_free == '0) |-> !ready;
	endproperty
	a_no_room: assert property (p_no_room) else $error("ready with no free slot");

	property p_commit_adds;
		push && !pop |=> q_count == $past(q_count) + 1'b1;
	endproperty
	a_commit_adds: assert property (p_commit_adds) else $error("commit lost");

	property p_refused;
		wr_commit && !ready && !pop |=> $stable(q_count) && $stable(stg_id_r);
	endproperty
	a_refused: assert property (p_refused) else $error("refused commit took effect");

	property p_start;
		state_r == spc_pkg::S_IDLE && run_ok && q_count != '0 && !flush
			##1 !flush ##1 !flush |-> seq_start_o;
	endproperty
	a_start: assert property (p_start) else $error("enabled queue not started");

	property p_mode_legal;
		mode_r != spc_pkg::MODE_BAD;
	endproperty
	a_mode_legal: assert property (p_mode_legal) else $error("illegal mode held");

	property p_mode_reset;
		mode_chg |=> wavegen_reset_o && q_count == '0 && state_r == spc_pkg::S_IDLE;
	endproperty
	a_mode_reset: assert property (p_mode_reset) else $error("mode change did not reset");

	property p_wait_queue;
		state_r == spc_pkg::S_WAIT |-> $past(is_queue);
	endproperty
	a_wait_queue: assert property (p_wait_queue) else $error("waiting outside queue mode");

	property p_done_batch;
		state_r == spc_pkg::S_DONE |-> $past(is_batch);
	endproperty
	a_done_batch: assert property (p_done_batch) else $error("done outside batch mode");

	property p_left_one;
		!is_batch |-> left_rd == spc_pkg::REP_MIN && rep_rd == spc_pkg::REP_MIN;
	endproperty
	a_left_one: assert property (p_left_one) else $error("repeat reads not 1");

	property p_clear;
		wr_clear |=> !enable_r && q_count == '0;
	endproperty
	a_clear: assert property (p_clear) else $error("clear left work behind");

	property p_timeout;
		tmo |-> limit_r != 32'h0000_0000 ##1 seq_abort_o;
	endproperty
	a_timeout: assert property (p_timeout) else $error("bad timeout abort");
endmodule
`default_nettype wire

/* dv/spc_seq_model.sv */
`default_nettype none
// sequencer stand-in: runs each started sequence for a few unstalled cycles, then reports done unless aborted
module spc_seq_model #(
	parameter int DLY = 3
) (
	input  wire logic sys_clk_i,
	input  wire logic srst_i,
	input  wire logic seq_start_i,
	input  wire logic seq_abort_i,
	input  wire logic stall_i,
	output logic      seq_done_o
);
	timeunit 1ns;
	timeprecision 1ns;
	logic busy_r;
	int   cnt_r;
	// done never comes before the start pulse was seen; an abort drops the run
	always @(posedge sys_clk_i) begin
		seq_done_o <= 1'b0;
		if (srst_i || seq_abort_i) begin
			busy_r <= 1'b0;
		end else if (seq_start_i) begin
			busy_r <= 1'b1;
			cnt_r  <= DLY;
		end else if (busy_r && !stall_i) begin
			// stall holds a run until stall falls or an abort drops it, so the watchdog can be exercised
			if (cnt_r == 0) begin
				seq_done_o <= 1'b1;
				busy_r     <= 1'b0;
			end else begin
				cnt_r <= cnt_r - 1;
			end
		end
	end
endmodule
`default_nettype wire

/* dv/tb_sequence_pipeliner_control.sv */
`default_nettype none
module tb_sequence_pipeliner_control;
	timeunit 1ns;
	timeprecision 1ns;
	localparam int DEP = 4;
	logic        sys_clk_i = 1'b0;
	logic        srst_i    = 1'b1;
	logic        hsel      = 1'b0;
	logic        hwrite    = 1'b0;
	logic        stall     = 1'b0;
	logic [31:0] haddr     = 32'h0000_0000;
	logic [31:0] hwdata    = 32'h0000_0000;
	logic [1:0]  htrans    = 2'h0;
	logic [2:0]  hsize     = 3'h2;
	logic [31:0] hrdata;
	logic [31:0] seq_id;
	logic [31:0] seq_data;
	logic [31:0] rd;
	logic [31:0] base;
	logic        hready;
	logic        seq_start;
	logic        seq_abort;
	logic        seq_done;
	logic        wg_rst;
	logic        hresp;
	int          num_errors = 0;
	int          n_compared = 0;
	int          n_wg       = 0;
	int          n_abort    = 0;
	int          n0;
	int          n1;
	logic [31:0] ids[$];
	logic [31:0] dats[$];

	spc_pipeliner #(.DEPTH(DEP), .DW(32), .MS_CYCLES(4)) dut_u (
		.sys_clk_i(sys_clk_i), .srst_i(srst_i), .hsel_i(hsel), .haddr_i(haddr),
		.htrans_i(htrans), .hwrite_i(hwrite), .hsize_i(hsize), .hwdata_i(hwdata),
		.hready_i(hready), .hrdata_o(hrdata), .hreadyout_o(hready), .hresp_o(hresp),
		.seq_start_o(seq_start), .seq_id_o(seq_id), .seq_data_o(seq_data),
		.seq_abort_o(seq_abort), .seq_done_i(seq_done), .wavegen_reset_o(wg_rst));

	spc_seq_model #(.DLY(3)) seq_u (
		.sys_clk_i(sys_clk_i), .srst_i(srst_i), .seq_start_i(seq_start),
		.seq_abort_i(seq_abort), .stall_i(stall), .seq_done_o(seq_done));

	// clock of 100 ns
	initial begin
		forever #50 sys_clk_i = ~sys_clk_i;
	end

	// log of launched sequences and one-cycle pulses
	always @(posedge sys_clk_i) begin
		if (seq_start) begin
			ids.push_back(seq_id);
			dats.push_back(seq_data);
		end
		if (wg_rst) n_wg++;
		if (seq_abort) n_abort++;
	end

	task automatic print_verdict;
		$display("errors %0d compared %0d", num_errors, n_compared);
		if (num_errors == 0 && n_compared > 0) $display("verification passed");
		else $display("verification failed");
		$finish;
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_compared++;
		if (got !== exp) begin
			num_errors++;
			$display("ERROR t=%0t got %h exp %h", $time, got, exp);
		end
	endtask

	// one ahb single transfer; every wait bounded
	task automatic xfer(input logic [7:0] ofs, input logic wr, input logic [31:0] wd);
		int n;
		@(posedge sys_clk_i);
		hsel   <= 1'b1;
		htrans <= 2'h2;
		hwrite <= wr;
		haddr  <= {24'h00_0000, ofs};
		n = 0;
		do begin @(posedge sys_clk_i); n++; end while (hready !== 1'b1 && n < 100);
		htrans <= 2'h0;
		hsel   <= 1'b0;
		hwdata <= wd;
		do begin @(posedge sys_clk_i); n++; end while (hready !== 1'b1 && n < 200);
		rd = hrdata;
		// the slave never signals an error response
		chk({31'h0000_0000, hresp}, 32'h0000_0000);
		if (n >= 200) begin
			num_errors++;
			print_verdict;
		end
	endtask

	task automatic wr(input logic [7:0] ofs, input logic [31:0] d);
		xfer(ofs, 1'b1, d);
	endtask

	task automatic rdchk(input logic [7:0] ofs, input logic [31:0] exp);
		xfer(ofs, 1'b0, 32'h0000_0000);
		chk(rd, exp);
	endtask

	// poll status until it matches, then compare once
	task automatic wait_stat(input logic [1:0] s);
		for (int k = 0; k < 200; k++) begin
			xfer(spc_pkg::OFS_STATUS, 1'b0, 32'h0000_0000);
			if (rd === {30'h0, s}) break;
		end
		chk(rd, {30'h0, s});
	endtask

	task automatic wait_starts(input int n);
		for (int k = 0; k < 500; k++) begin
			if (ids.size() >= n) break;
			@(posedge sys_clk_i);
		end
		chk(ids.size(), n);
	endtask

	// hang guard
	initial begin
		repeat (90000) @(posedge sys_clk_i);
		num_errors++;
		print_verdict;
	end

	initial begin
		repeat (4) @(posedge sys_clk_i);
		srst_i <= 1'b0;
		// reset values and an unmapped word
		rdchk(spc_pkg::OFS_CAP, DEP);
		rdchk(spc_pkg::OFS_FREE, DEP);
		rdchk(spc_pkg::OFS_MODE, 32'h0000_0000);
		rdchk(spc_pkg::OFS_REP_LFT, 32'h0000_0001);
		rdchk(spc_pkg::OFS_REP_SET, 32'h0000_0001);
		rdchk(spc_pkg::OFS_STATUS, spc_pkg::STAT_IDLE);
		rdchk(8'h3C, 32'h0000_0000);
		// off mode: nothing can be committed
		rdchk(spc_pkg::OFS_READY, 32'h0000_0000);
		wr(spc_pkg::OFS_COMMIT, 32'h0000_0001);
		rdchk(spc_pkg::OFS_FREE, DEP);
		rdchk(spc_pkg::OFS_STG_ID, 32'h0000_0000);
		wr(spc_pkg::OFS_REP_SET, 32'h0000_0005);
		rdchk(spc_pkg::OFS_REP_SET, 32'h0000_0001);
		// queue mode: commit three, run, then commit while waiting
		wr(spc_pkg::OFS_MODE, spc_pkg::MODE_QUEUE);
		wr(spc_pkg::OFS_MODE, spc_pkg::MODE_BAD);
		rdchk(spc_pkg::OFS_MODE, spc_pkg::MODE_QUEUE);
		chk(n_wg, 1);
		xfer(spc_pkg::OFS_STG_ID, 1'b0, 32'h0000_0000);
		base = rd;
		for (int i = 0; i < 3; i++) begin
			wr(spc_pkg::OFS_STG_DAT, 32'h0000_A000 + i);
			wr(spc_pkg::OFS_COMMIT, 32'h0000_0001);
			rdchk(spc_pkg::OFS_STG_ID, base + i + 1);
		end
		rdchk(spc_pkg::OFS_FREE, DEP - 3);
		rdchk(spc_pkg::OFS_READY, 32'h0000_0001);
		wr(spc_pkg::OFS_ENABLE, 32'h0000_0001);
		wait_stat(spc_pkg::STAT_WAIT);
		wr(spc_pkg::OFS_STG_DAT, 32'h0000_A003);
		wr(spc_pkg::OFS_COMMIT, 32'h0000_0001);
		wait_starts(4);
		wait_stat(spc_pkg::STAT_WAIT);
		for (int i = 0; i < 4; i++) begin
			chk(ids[i], base + i);
			chk(dats[i], 32'h0000_A000 + i);
		end
		rdchk(spc_pkg::OFS_FREE, DEP);
		rdchk(spc_pkg::OFS_RUN_ID, base + 3);
		rdchk(spc_pkg::OFS_REP_LFT, 32'h0000_0001);
		// fill until refused, then one more commit
		wr(spc_pkg::OFS_ENABLE, 32'h0000_0000);
		wait_stat(spc_pkg::STAT_IDLE);
		for (int i = 0; i < DEP; i++) wr(spc_pkg::OFS_COMMIT, 32'h0000_0001);
		rdchk(spc_pkg::OFS_FREE, 32'h0000_0000);
		rdchk(spc_pkg::OFS_READY, 32'h0000_0000);
		xfer(spc_pkg::OFS_STG_ID, 1'b0, 32'h0000_0000);
		base = rd;
		wr(spc_pkg::OFS_COMMIT, 32'h0000_0001);
		rdchk(spc_pkg::OFS_STG_ID, base);
		rdchk(spc_pkg::OFS_FREE, 32'h0000_0000);
		// clear in mid-run
		wr(spc_pkg::OFS_ENABLE, 32'h0000_0001);
		wait_starts(5);
		wr(spc_pkg::OFS_CLEAR, 32'h0000_0001);
		rdchk(spc_pkg::OFS_ENABLE, 32'h0000_0000);
		rdchk(spc_pkg::OFS_FREE, DEP);
		wait_stat(spc_pkg::STAT_IDLE);
		// batch mode: clamp, then two slots run twice
		wr(spc_pkg::OFS_MODE, spc_pkg::MODE_BATCH);
		// the reset pulse is logged on the edge the write returns on
		@(posedge sys_clk_i);
		chk(n_wg, 2);
		wr(spc_pkg::OFS_REP_SET, 32'h0000_0000);
		rdchk(spc_pkg::OFS_REP_SET, spc_pkg::REP_MIN);
		wr(spc_pkg::OFS_REP_SET, 32'hFFFF_FFFF);
		rdchk(spc_pkg::OFS_REP_SET, spc_pkg::REP_MAX);
		wr(spc_pkg::OFS_REP_SET, 32'h0000_0002);
		xfer(spc_pkg::OFS_STG_ID, 1'b0, 32'h0000_0000);
		base = rd;
		n0 = ids.size();
		for (int i = 0; i < 2; i++) wr(spc_pkg::OFS_COMMIT, 32'h0000_0001);
		wr(spc_pkg::OFS_ENABLE, 32'h0000_0001);
		wait_stat(spc_pkg::STAT_DONE);
		chk(ids.size(), n0 + 4);
		for (int i = 0; i < 4; i++) chk(ids[n0 + i], base + (i % 2));
		rdchk(spc_pkg::OFS_REP_LFT, 32'h0000_0000);
		// watchdog: one millisecond aborts a stalled run, zero never does
		wr(spc_pkg::OFS_MODE, spc_pkg::MODE_QUEUE);
		wr(spc_pkg::OFS_TIMEOUT, 32'h0000_0001);
		stall <= 1'b1;
		n0 = n_abort;
		wr(spc_pkg::OFS_COMMIT, 32'h0000_0001);
		wr(spc_pkg::OFS_ENABLE, 32'h0000_0001);
		wait_stat(spc_pkg::STAT_WAIT);
		chk(n_abort, n0 + 1);
		wr(spc_pkg::OFS_TIMEOUT, 32'h0000_0000);
		n1 = n_abort;
		n0 = ids.size();
		wr(spc_pkg::OFS_COMMIT, 32'h0000_0001);
		wait_starts(n0 + 1);
		// well past four cycles of one millisecond here
		repeat (40) @(posedge sys_clk_i);
		rdchk(spc_pkg::OFS_STATUS, spc_pkg::STAT_EXEC);
		chk(n_abort, n1);
		stall <= 1'b0;
		wait_stat(spc_pkg::STAT_WAIT);
		// back to off: another reset pulse, and nothing can be committed
		wr(spc_pkg::OFS_MODE, spc_pkg::MODE_OFF);
		rdchk(spc_pkg::OFS_MODE, 32'h0000_0000);
		rdchk(spc_pkg::OFS_READY, 32'h0000_0000);
		chk(n_wg, 4);
		print_verdict;
	end
endmodule
`default_nettype wire
